//--- tcc_map.svh
// Register offsets, field positions and reset values of the timer block.
// Assumes a byte address of eight bits and one 32-bit word per register.
`ifndef TCC_MAP_SVH
`define TCC_MAP_SVH

// Base of each group of units and the spacing between two units.
`define TCC_TMR_BASE  8'h00
`define TCC_OC_BASE   8'h50
`define TCC_IC_BASE   8'ha0
`define TCC_IRQ_BASE  8'hf0
`define TCC_STRIDE    16

// Word offsets inside one unit.
`define TCC_R_CTRL    8'h00
`define TCC_R_VAL     8'h04
`define TCC_R_AUX     8'h08
`define TCC_R_MASK    8'h04

// Timer control fields.
`define TCC_T_EN      0
`define TCC_T_PSC     3:1
`define TCC_T_CLR     4
`define TCC_T_IRQ     5
`define TCC_T_JOIN    6

// Compare and capture control fields and the capture overflow status bit.
`define TCC_OC_MODE   2:0
`define TCC_OC_TSEL   3
`define TCC_IC_EDGE   1:0
`define TCC_IC_TSEL   2
`define TCC_IC_IRQ    3
`define TCC_IC_OVF    4

// Interrupt status layout.
`define TCC_ST_TMR    4:0
`define TCC_ST_OC     9:5
`define TCC_ST_IC     14:10

// Period reset value and capture queue depth.
`define TCC_PER_RST   16'hffff
`define TCC_FIFO_DEPTH 3'h4

`endif

//--- tcc_pkg.sv
// Types shared by the timer block and its compare and capture units.
// Assumes the map header is included by every user of these types.
package tcc_pkg;

	// Output compare modes.
	typedef enum logic [2:0] {
		TCC_OC_OFF    = 3'b000,
		TCC_OC_RISE   = 3'b001,
		TCC_OC_FALL   = 3'b010,
		TCC_OC_TOGGLE = 3'b011,
		TCC_OC_SINGLE = 3'b100,
		TCC_OC_CONT   = 3'b101,
		TCC_OC_PWM    = 3'b110
	} tcc_oc_mode_t;

	// Capture edge selection.
	typedef enum logic [1:0] {
		TCC_IC_NONE = 2'b00,
		TCC_IC_RISE = 2'b01,
		TCC_IC_FALL = 2'b10,
		TCC_IC_BOTH = 2'b11
	} tcc_edge_t;

	// Configuration handed to one compare unit.
	typedef struct packed {
		tcc_oc_mode_t mode;
		logic [15:0]  r;
		logic [15:0]  rs;
	} tcc_oc_cfg_t;

	// State of one compare unit.
	typedef struct packed {
		logic        pin;
		logic [15:0] prev;
		logic        done;
		logic        hit;
	} tcc_oc_st_t;

	// State of one capture unit.
	typedef struct packed {
		logic [3:0][15:0] mem;
		logic [1:0]       wptr;
		logic [1:0]       rptr;
		logic [2:0]       level;
		logic             ovf;
		logic             prev_pin;
	} tcc_ic_st_t;

	// State of the top level.
	typedef struct packed {
		logic [4:0][6:0]  tctl;
		logic [4:0][15:0] tcnt;
		logic [4:0][15:0] tper;
		logic [4:0][7:0]  psc;
		logic [4:0][3:0]  octl;
		logic [4:0][15:0] ocr;
		logic [4:0][15:0] ocrs;
		logic [4:0][3:0]  ictl;
		logic [14:0]      ist;
		logic [14:0]      imsk;
		logic [31:0]      rdata;
		logic             irq;
	} tcc_top_st_t;

endpackage : tcc_pkg

//--- tcc_compare.sv
// One output compare unit driving one dedicated pin.
// Assumes a 16-bit time base that the top level selects for it.
`timescale 1ns/1ps
`include "tcc_map.svh"

module tcc_compare
	import tcc_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire tcc_oc_cfg_t cfg,
	input  wire logic        arm,
	input  wire logic [15:0] count,
	output logic             pin,
	output logic             hit
);

	tcc_oc_st_t s;
	tcc_oc_st_t n;
	logic       step;
	logic       at_r;
	logic       at_rs;
	logic       at_zero;

	// Matches count only when the time base has moved, so a stopped
	// timer sitting on the compare value does not fire again.
	always_comb begin
		n       = s;
		n.prev  = count;
		step    = (count != s.prev);
		at_r    = step && (count == cfg.r);
		at_rs   = step && (count == cfg.rs);
		at_zero = step && (count == 16'h0000);
		if (arm) begin
			n.done = 1'b0;
		end
		case (cfg.mode)
			TCC_OC_OFF: begin
				n.pin = 1'b0;
			end
			TCC_OC_RISE: begin
				if (at_r) n.pin = 1'b1;
			end
			TCC_OC_FALL: begin
				if (at_r) n.pin = 1'b0;
			end
			TCC_OC_TOGGLE: begin
				if (at_r) n.pin = ~s.pin;
			end
			TCC_OC_SINGLE: begin
				if (!s.done && at_r) n.pin = 1'b1;
				if (!s.done && at_rs) begin
					n.pin  = 1'b0;
					n.done = 1'b1;
				end
			end
			TCC_OC_CONT: begin
				if (at_r) n.pin = 1'b1;
				if (at_rs) n.pin = 1'b0;
			end
			TCC_OC_PWM: begin
				if (at_zero) n.pin = 1'b1;
				if (at_r) n.pin = 1'b0;
			end
			default: begin
				n.pin = 1'b0;
			end
		endcase
		n.hit = at_r && (cfg.mode != TCC_OC_OFF) &&
			(cfg.mode <= TCC_OC_PWM);
	end

	// State register.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign pin = s.pin;
	assign hit = s.hit;

endmodule : tcc_compare

//--- tcc_capture.sv
// One input capture unit with a four-entry queue of captured counts.
// Assumes its pin is synchronous to clk and a one-cycle pop strobe.
`timescale 1ns/1ps
`include "tcc_map.svh"

module tcc_capture
	import tcc_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire tcc_edge_t   edge_sel,
	input  wire logic [15:0] count,
	input  wire logic        pin,
	input  wire logic        pop,
	input  wire logic        clr_ovf,
	output logic [15:0]      head,
	output logic [2:0]       level,
	output logic             ovf,
	output logic             event_hit
);

	tcc_ic_st_t s;
	tcc_ic_st_t n;
	logic       rise;
	logic       fall;
	logic       take;
	logic       do_pop;
	logic       full;

	// Edge detection, queue push and pop, overflow flag.
	always_comb begin
		n          = s;
		n.prev_pin = pin;
		rise       = pin && !s.prev_pin;
		fall       = !pin && s.prev_pin;
		case (edge_sel)
			TCC_IC_RISE: take = rise;
			TCC_IC_FALL: take = fall;
			TCC_IC_BOTH: take = rise || fall;
			default:     take = 1'b0;
		endcase
		do_pop = pop && (s.level != 3'h0);
		full   = (s.level == `TCC_FIFO_DEPTH) && !do_pop;
		if (do_pop) begin
			n.rptr = s.rptr + 2'h1;
		end
		if (take && !full) begin
			n.mem[s.wptr] = count;
			n.wptr        = s.wptr + 2'h1;
		end
		n.level = s.level + {2'h0, take && !full} - {2'h0, do_pop};
		if (clr_ovf) begin
			n.ovf = 1'b0;
		end
		if (take && full) begin
			n.ovf = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s         <= '0;
			event_hit <= 1'b0;
		end else begin
			s         <= n;
			event_hit <= take;
		end
	end

	assign head  = s.mem[s.rptr];
	assign level = s.level;
	assign ovf   = s.ovf;

endmodule : tcc_capture

//--- tcc_top.sv
// Timer block: five timers, five compare pins, five capture pins,
// a plain register port and one level interrupt.
// Assumes one 40 MHz clock and pins synchronous to it.
// Assumes software never raises the read and write strobes together.
//
// What this block does
// - Five independent timers, each with a 16-bit counter.
// - Second and third, fourth and fifth timers join into 32-bit timers.
// - Each timer has control, counter and period registers.
// - Counter advances per bus clock or per prescaled bus clock.
// - Period match raises interrupt, clears counter, or both.
// - Five compare units, each driving only its own pin.
// - Compare modes: PWM, pulse train, single pulse, toggle, fall, rise.
// - Each compare unit selects second or third timer as base.
// - Five capture units, each watching its own pin.
// - A qualifying pin change latches the selected timer count.
// - Each capture unit selects second or third timer as source.
// - Capture on rising, falling, or both edges.
// - Capture event optionally raises an interrupt.
// - Captured values queue in a four-entry FIFO.
//
// Added by the designer: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`include "tcc_map.svh"

module tcc_top
	import tcc_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic [7:0]  bus_addr,
	input  wire logic [31:0] bus_wdata,
	input  wire logic        bus_wr,
	input  wire logic        bus_rd,
	output logic [31:0]      bus_rdata,
	input  wire logic [4:0]  capture_pin,
	output logic [4:0]       compare_pin,
	output logic             irq
);

	// Registered state and its next value.
	tcc_top_st_t      s;
	tcc_top_st_t      n;
	// Reset synchroniser and the copy of reset used inside.
	logic [1:0]       rsync;
	logic             rst_n;
	// Per-timer step, match event and wrap strobes.
	logic [4:0]       tick;
	logic [4:0]       tev;
	logic [4:0]       wrap;
	// Compare unit wiring.
	logic [4:0]       oc_arm;
	logic [4:0]       oc_hit;
	tcc_oc_cfg_t      oc_cfg [5];
	logic [4:0][15:0] oc_base;
	// Capture unit wiring.
	logic [4:0]       ic_pop;
	logic [4:0]       ic_clr;
	logic [4:0][15:0] ic_head;
	logic [4:0][2:0]  ic_lvl;
	logic [4:0]       ic_ovf;
	logic [4:0]       ic_ev;
	logic [4:0][15:0] ic_base;
	// Events that feed the sticky status word.
	logic [14:0]      events;

	// Register map, one 32-bit word per register, data in the low bits.
	// Timer i sits at 0x00 + 0x10 * i: control at +0, count at +4 and
	// period at +8. Timer control holds enable in bit 0, the prescale
	// exponent in bits 3:1, clear on match in bit 4, interrupt on match
	// in bit 5 and the join bit in bit 6.
	// Compare unit j sits at 0x50 + 0x10 * j: control at +0 with the mode
	// in bits 2:0 and the time base in bit 3, then the first and second
	// compare values at +4 and +8.
	// Capture unit k sits at 0xa0 + 0x10 * k: control at +0 with the edge
	// choice in bits 1:0, the source in bit 2 and the interrupt enable in
	// bit 3; the queue word at +4, whose read pops the oldest entry; and
	// the status word at +8 with the level in bits 2:0 and the overflow
	// flag in bit 4, which a write of one to bit 4 clears.
	// The interrupt status word sits at 0xf0 and clears on read; the mask
	// sits at 0xf4 with the same layout.
	// Offset 0xc of every unit and all other words read as zero.

	// Byte address of register off of unit idx in a group.
	// The sum is cut to eight bits on purpose; the map stays below 0x100.
	function automatic logic [7:0] word_addr(input logic [7:0] base,
		input int idx, input logic [7:0] off);
		return 8'(base + 8'(idx * `TCC_STRIDE) + off);
	endfunction : word_addr

	// Terminal prescaler count for a divide by two to the power sel.
	// An exponent of seven gives 127, which fits the 8-bit counter.
	function automatic logic [7:0] psc_limit(input logic [2:0] sel);
		return 8'((9'h001 << sel) - 9'h001);
	endfunction : psc_limit

	// True when timer i is the upper half of a joined pair.
	// joinable timer pairs.
	function automatic logic join_hi(input tcc_top_st_t st, input int i);
		return (i == 2 && st.tctl[1][`TCC_T_JOIN]) ||
			(i == 4 && st.tctl[3][`TCC_T_JOIN]);
	endfunction : join_hi

	// True when timer i is the lower half of a joined pair.
	// Only timers one and three carry a meaningful join bit.
	function automatic logic join_lo(input tcc_top_st_t st, input int i);
		return (i == 1 || i == 3) && st.tctl[i][`TCC_T_JOIN];
	endfunction : join_lo

	// Reset is released through two flip-flops, so every register leaves
	// reset on the same edge however the external release lines up.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rsync <= 2'h0;
		end else begin
			rsync <= {rsync[0], 1'b1};
		end
	end
	assign rst_n = rsync[1];

	// Timers, register writes and reads, interrupt status.
	// A timer steps when it is enabled and its prescale counter reaches
	// two to the power of the exponent less one; an exponent of zero
	// steps it every cycle. On a step the count is compared with the
	// period before it moves, so with clear on match a period of p gives p + 1 counts.
	// A joined pair steps its upper half only when the lower half steps
	// from 0xffff; the lower half never matches its period, and the upper
	// half keeps its own period, clear and interrupt bits while its own
	// enable and prescale are ignored.
	// A register write lands on the edge that samples it and wins over a
	// step of the same counter; read data are registered and stand for
	// exactly one cycle, zero otherwise.
	always_comb begin
		n      = s;
		tick   = '0;
		tev    = '0;
		wrap   = '0;
		oc_arm = '0;
		ic_pop = '0;
		ic_clr = '0;
		for (int i = 0; i < 5; i++) begin
			if (join_hi(s, i)) begin
				tick[i] = tick[i-1] && (s.tcnt[i-1] == 16'hffff);
				// The upper half keeps no prescale count of its own.
				n.psc[i] = 8'h00;
			end else if (s.tctl[i][`TCC_T_EN]) begin
				tick[i]  = (s.psc[i] == psc_limit(s.tctl[i][`TCC_T_PSC]));
				n.psc[i] = tick[i] ? 8'h00 : 8'(s.psc[i] + 8'h01);
			end else begin
				n.psc[i] = 8'h00;
			end
			// period match actions.
			// A match is taken only on a step, so a stopped timer that
			// rests on its period posts no further events.
			wrap[i] = tick[i] && !join_lo(s, i) && (s.tcnt[i] == s.tper[i]);
			tev[i]  = wrap[i] && s.tctl[i][`TCC_T_IRQ];
			if (wrap[i] && s.tctl[i][`TCC_T_CLR]) begin
				n.tcnt[i] = 16'h0000;
			end else if (tick[i]) begin
				n.tcnt[i] = 16'(s.tcnt[i] + 16'h0001);
			end
		end
		// Register writes; a write to a counter wins over counting.
		// Writes to unmapped or read-only words are dropped.
		if (bus_wr) begin
			for (int i = 0; i < 5; i++) begin
				if (bus_addr == word_addr(`TCC_TMR_BASE, i, `TCC_R_CTRL))
					n.tctl[i] = bus_wdata[6:0];
				if (bus_addr == word_addr(`TCC_TMR_BASE, i, `TCC_R_VAL))
					n.tcnt[i] = bus_wdata[15:0];
				if (bus_addr == word_addr(`TCC_TMR_BASE, i, `TCC_R_AUX))
					n.tper[i] = bus_wdata[15:0];
				if (bus_addr == word_addr(`TCC_OC_BASE, i, `TCC_R_CTRL)) begin
					n.octl[i] = bus_wdata[3:0];
					oc_arm[i] = 1'b1;
				end
				if (bus_addr == word_addr(`TCC_OC_BASE, i, `TCC_R_VAL))
					n.ocr[i] = bus_wdata[15:0];
				if (bus_addr == word_addr(`TCC_OC_BASE, i, `TCC_R_AUX))
					n.ocrs[i] = bus_wdata[15:0];
				if (bus_addr == word_addr(`TCC_IC_BASE, i, `TCC_R_CTRL))
					n.ictl[i] = bus_wdata[3:0];
				if (bus_addr == word_addr(`TCC_IC_BASE, i, `TCC_R_AUX))
					ic_clr[i] = bus_wdata[`TCC_IC_OVF];
			end
			if (bus_addr == word_addr(`TCC_IRQ_BASE, 0, `TCC_R_MASK))
				n.imsk = bus_wdata[14:0];
		end
		// Register reads; unmapped addresses read as zero. Only one
		// address matches, so the order of the tests does not matter.
		n.rdata = 32'h0000_0000;
		if (bus_rd) begin
			for (int i = 0; i < 5; i++) begin
				if (bus_addr == word_addr(`TCC_TMR_BASE, i, `TCC_R_CTRL))
					n.rdata = {25'h0, s.tctl[i]};
				if (bus_addr == word_addr(`TCC_TMR_BASE, i, `TCC_R_VAL))
					n.rdata = {16'h0, s.tcnt[i]};
				if (bus_addr == word_addr(`TCC_TMR_BASE, i, `TCC_R_AUX))
					n.rdata = {16'h0, s.tper[i]};
				if (bus_addr == word_addr(`TCC_OC_BASE, i, `TCC_R_CTRL))
					n.rdata = {28'h0, s.octl[i]};
				if (bus_addr == word_addr(`TCC_OC_BASE, i, `TCC_R_VAL))
					n.rdata = {16'h0, s.ocr[i]};
				if (bus_addr == word_addr(`TCC_OC_BASE, i, `TCC_R_AUX))
					n.rdata = {16'h0, s.ocrs[i]};
				if (bus_addr == word_addr(`TCC_IC_BASE, i, `TCC_R_CTRL))
					n.rdata = {28'h0, s.ictl[i]};
				// A read of the queue word pops its oldest entry.
				// An empty queue shows the stale slot at its read pointer and is not popped.
				if (bus_addr == word_addr(`TCC_IC_BASE, i, `TCC_R_VAL)) begin
					n.rdata   = {16'h0, ic_head[i]};
					ic_pop[i] = 1'b1;
				end
				if (bus_addr == word_addr(`TCC_IC_BASE, i, `TCC_R_AUX))
					n.rdata = {27'h0, ic_ovf[i], 1'b0, ic_lvl[i]};
			end
			if (bus_addr == word_addr(`TCC_IRQ_BASE, 0, `TCC_R_CTRL))
				n.rdata = {17'h0, s.ist};
			if (bus_addr == word_addr(`TCC_IRQ_BASE, 0, `TCC_R_MASK))
				n.rdata = {17'h0, s.imsk};
		end
		// Status clears on read, but a new event in that cycle survives,
		// so software that reads the word never loses an event.
		if (bus_rd && bus_addr == word_addr(`TCC_IRQ_BASE, 0, `TCC_R_CTRL))
			n.ist = 15'h0000;
		n.ist = n.ist | events;
		n.irq = |(n.ist & n.imsk);
	end

	// Events that set sticky status bits. Timer and capture events obey
	// their own enable bits; compare hits always post and the mask alone
	// decides whether they reach the interrupt line.
	always_comb begin
		events = '0;
		events[`TCC_ST_TMR] = tev;
		events[`TCC_ST_OC]  = oc_hit;
		for (int i = 0; i < 5; i++) begin
			events[10 + i] = ic_ev[i] && s.ictl[i][`TCC_IC_IRQ];
		end
	end

	// State register. Periods reset to all ones so an enabled timer with
	// an untouched period runs the full 16-bit range.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s      <= '0;
			s.tper <= {5{`TCC_PER_RST}};
		end else begin
			s <= n;
		end
	end

	// Outputs come straight from the state register.
	assign bus_rdata = s.rdata;
	assign irq       = s.irq;

	// Compare and capture units. Both see the live count of the first
	// or second joinable timer, so pin timing depends only on the timer
	// and on the unit's own setup.
	// Compare modes: 0 off, 1 set at the first value, 2 clear at it,
	// 3 toggle at it, 4 one pulse from the first to the second value
	// until the control word is written again, 5 a pulse each period
	// between the two values, 6 PWM that sets on a step to zero and
	// clears at the first value; 7 holds the pin low like mode 0.
	// Capture edges: 0 none, 1 rising, 2 falling, 3 both.
	for (genvar j = 0; j < 5; j++) begin : g_unit
		assign oc_base[j] = s.octl[j][`TCC_OC_TSEL] ? s.tcnt[2] : s.tcnt[1];
		// The mode field is cast as it is; code 7 acts as off in the unit.
		assign oc_cfg[j]  = '{mode: tcc_oc_mode_t'(s.octl[j][`TCC_OC_MODE]),
			r: s.ocr[j], rs: s.ocrs[j]};
		assign ic_base[j] = s.ictl[j][`TCC_IC_TSEL] ? s.tcnt[2] : s.tcnt[1];

		tcc_compare u_cmp (
			.clk   (clk),
			.rst_n (rst_n),
			.cfg   (oc_cfg[j]),
			.arm   (oc_arm[j]),
			.count (oc_base[j]),
			.pin   (compare_pin[j]),
			.hit   (oc_hit[j])
		);

		tcc_capture u_cap (
			.clk       (clk),
			.rst_n     (rst_n),
			.edge_sel  (tcc_edge_t'(s.ictl[j][`TCC_IC_EDGE])),
			.count     (ic_base[j]),
			.pin       (capture_pin[j]),
			.pop       (ic_pop[j]),
			.clr_ovf   (ic_clr[j]),
			.head      (ic_head[j]),
			.level     (ic_lvl[j]),
			.ovf       (ic_ovf[j]),
			.event_hit (ic_ev[j])
		);
	end

endmodule : tcc_top

//--- tcc_top_chk.sv
// Checker of the timer block, seeing only the top-level ports.
// Assumes the register map of the block and a bind from the bench.
`timescale 1ns/1ps

module tcc_top_chk
	import tcc_pkg::*;
(
	input wire logic        clk,
	input wire logic        resetn,
	input wire logic [7:0]  bus_addr,
	input wire logic [31:0] bus_wdata,
	input wire logic        bus_wr,
	input wire logic        bus_rd,
	input wire logic [31:0] bus_rdata,
	input wire logic [4:0]  capture_pin,
	input wire logic [4:0]  compare_pin,
	input wire logic        irq
);
	logic [2:0]  mode0;
	logic [14:0] mask;

	// Mirrors of the first compare mode and of the interrupt mask.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			mode0 <= 3'h0;
			mask  <= 15'h0;
		end else if (bus_wr) begin
			if (bus_addr == 8'h50)
				mode0 <= bus_wdata[2:0];
			if (bus_addr == 8'hf4)
				mask <= bus_wdata[14:0];
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);

	// Reads of the mask, of capture status and of unmapped words.
	sequence s_rd_mask;
		bus_rd && bus_addr == 8'hf4;
	endsequence
	sequence s_rd_icst;
		bus_rd && bus_addr >= 8'ha0 && bus_addr < 8'hf0 && bus_addr[3:0] == 4'h8;
	endsequence
	sequence s_rd_hole;
		bus_rd && (bus_addr[3:0] == 4'hc || bus_addr == 8'hf8);
	endsequence

	rdata_idle_a: assert property (!$past(bus_rd) |-> bus_rdata == 32'h0)
		else $error("Read data not zero outside a read answer.");
	rdata_width_a: assert property (bus_rdata[31:16] == 16'h0)
		else $error("Upper half of read data not zero.");
	hole_read_a: assert property (s_rd_hole |=> bus_rdata == 32'h0)
		else $error("Unmapped read returned data.");
	mask_back_a: assert property (s_rd_mask |=> bus_rdata == {17'h0, mask})
		else $error("Mask read back differs from last write.");
	queue_level_a: assert property (s_rd_icst |=>
		bus_rdata[2:0] <= 3'h4 && !bus_rdata[3])
		else $error("Capture queue level above four.");
	rise_hold_a: assert property (mode0 == TCC_OC_RISE &&
		$past(mode0) == TCC_OC_RISE && $past(mode0, 2) == TCC_OC_RISE
		|-> !$fell(compare_pin[0]))
		else $error("Compare pin fell in rising-edge mode.");
	fall_hold_a: assert property (mode0 == TCC_OC_FALL &&
		$past(mode0) == TCC_OC_FALL && $past(mode0, 2) == TCC_OC_FALL
		|-> !$rose(compare_pin[0]))
		else $error("Compare pin rose in falling-edge mode.");
	mask_quiet_a: assert property (mask == 15'h0 && $past(mask) == 15'h0 &&
		$past(mask, 2) == 15'h0 |-> !irq)
		else $error("Interrupt raised while fully masked.");

endmodule : tcc_top_chk

//--- tcc_pins.sv
// Model of the pins outside the block: capture drivers, compare watchers.
// Assumes the bench calls its tasks and the pins share the block clock.
`timescale 1ns/1ps

module tcc_pins (
	input  wire logic       clk,
	input  wire logic [4:0] compare_pin,
	output logic [4:0]      capture_pin
);
	logic [4:0] prev = 5'h0;
	int         rises [5];

	initial capture_pin = 5'h0;

	// Counts rising edges seen on each compare pin.
	always @(posedge clk) begin
		prev <= compare_pin;
		for (int i = 0; i < 5; i++)
			if (compare_pin[i] === 1'b1 && prev[i] === 1'b0)
				rises[i]++;
	end

	task clear;
		foreach (rises[i]) rises[i] = 0;
	endtask : clear

	// One high pulse of h cycles then l low cycles on one capture pin.
	task pulse(input int k, input int h, input int l);
		@(posedge clk);
		capture_pin[k] <= 1'b1;
		repeat (h) @(posedge clk);
		capture_pin[k] <= 1'b0;
		repeat (l) @(posedge clk);
	endtask : pulse

endmodule : tcc_pins

//--- tcc_top_tb.sv
// Self-checking bench of the timer block with a pin model beside it.
// Assumes the register map of the block and a 40 MHz clock.
`timescale 1ns/1ps

module tcc_top_tb;
	import tcc_pkg::*;
	logic        clk = 1'b0;
	logic        resetn = 1'b0;
	logic [7:0]  bus_addr = 8'h0;
	logic [31:0] bus_wdata = 32'h0;
	logic        bus_wr = 1'b0;
	logic        bus_rd = 1'b0;
	logic [31:0] bus_rdata, d, prev;
	logic [31:0] seed = 32'h2997;
	logic [4:0]  capture_pin, compare_pin;
	logic        irq;
	logic [7:0]  base;
	int          fail_count = 0, n_compared = 0, k, t;
	tcc_oc_mode_t modes [7] = '{TCC_OC_OFF, TCC_OC_RISE, TCC_OC_FALL,
		TCC_OC_SINGLE, TCC_OC_TOGGLE, TCC_OC_CONT, TCC_OC_PWM};
	int          lo [7] = '{0, 1, 0, 1, 2, 3, 3};
	int          hi [7] = '{0, 1, 0, 1, 3, 5, 5};
	logic [31:0] lev [4] = '{32'h0, 32'h1, 32'h2, 32'h4};

	always #12.5 clk = ~clk;

	tcc_top tcc_top_i (.clk(clk), .resetn(resetn), .bus_addr(bus_addr),
		.bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
		.bus_rdata(bus_rdata), .capture_pin(capture_pin),
		.compare_pin(compare_pin), .irq(irq));
	tcc_pins tcc_pins_i (.clk(clk), .compare_pin(compare_pin),
		.capture_pin(capture_pin));

	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	task wrap_up;
		$display("Compared %0d, mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : wrap_up

	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("Error at %0t: got %h, want %h", $time, got, exp);
		end
	endtask : chk

	task chk_in(input logic [31:0] got, input logic [31:0] l,
		input logic [31:0] h);
		n_compared++;
		if ((got >= l && got <= h) !== 1'b1) begin
			fail_count++;
			$display("Error at %0t: %h outside %h..%h", $time, got, l, h);
		end
	endtask : chk_in

	task wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		bus_addr <= a;
		bus_wdata <= v;
		bus_wr <= 1'b1;
		@(posedge clk);
		bus_wr <= 1'b0;
	endtask : wr

	task rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge clk);
		bus_addr <= a;
		bus_rd <= 1'b1;
		@(posedge clk);
		bus_rd <= 1'b0;
		@(negedge clk);
		v = bus_rdata;
	endtask : rd

	task wait_irq(input logic lvl);
		for (int n = 0; n < 200 && irq !== lvl; n++) @(negedge clk);
		chk({31'h0, irq}, {31'h0, lvl});
		if (irq !== lvl) wrap_up();
	endtask : wait_irq

	// Cuts a hung run short.
	initial begin
		#(25 * 60000);
		fail_count++;
		wrap_up();
	end

	initial begin
		repeat (12) @(posedge clk);
		resetn <= 1'b1;
		repeat (3) @(posedge clk);
		for (int i = 0; i < 5; i++) begin
			rd(8'(16 * i + 8), d);
			chk(d, 32'hffff);
			rd(8'(16 * i), d);
			chk(d, 32'h0);
		end
		rd(8'h0c, d);
		chk(d, 32'h0);
		rd(8'hf8, d);
		chk(d, 32'h0);
		wr(8'h08, 32'h2);
		wr(8'hf4, 32'h1);
		wr(8'h00, 32'h31);
		wait_irq(1'b1);
		rd(8'h04, d);
		chk_in(d, 32'h0, 32'h2);
		wr(8'h00, 32'h0);
		rd(8'hf0, d);
		chk(d & 32'h1, 32'h1);
		wait_irq(1'b0);
		wr(8'h08, 32'hffff);
		for (int n = 0; n < 4; n++) begin
			wr(8'h04, 32'h0);
			wr(8'h00, 32'h1 | (n << 1));
			repeat (64) @(posedge clk);
			wr(8'h00, 32'h0);
			rd(8'h04, d);
			chk_in(d, (64 >> n) - 1, (68 >> n) + 1);
		end
		wr(8'h14, 32'hfff0);
		wr(8'h18, 32'h5);
		wr(8'h24, 32'h0);
		wr(8'h10, 32'h51);
		repeat (40) @(posedge clk);
		wr(8'h10, 32'h0);
		rd(8'h24, d);
		chk(d, 32'h1);
		rd(8'h14, d);
		chk_in(d, 32'h10, 32'h30);
		wr(8'h18, 32'h40);
		wr(8'h28, 32'h40);
		wr(8'h14, 32'h0);
		wr(8'h24, 32'h0);
		wr(8'h10, 32'h11);
		wr(8'h20, 32'h11);
		wr(8'h54, 32'h10);
		wr(8'h58, 32'h20);
		for (int m = 0; m < 7; m++) begin
			tcc_pins_i.clear();
			wr(8'h50, {28'h0, 1'(rnd()), 3'(modes[m])});
			repeat (260) @(posedge clk);
			@(negedge clk);
			chk_in(32'(tcc_pins_i.rises[0]), lo[m], hi[m]);
			chk(32'(tcc_pins_i.rises[1] + tcc_pins_i.rises[2] +
				tcc_pins_i.rises[3] + tcc_pins_i.rises[4]), 32'h0);
		end
		k = int'(rnd() % 5);
		t = int'(rnd() & 32'h1);
		base = 8'(8'ha0 + 16 * k);
		wr(8'h18, 32'hffff);
		wr(8'h28, 32'hffff);
		wr(8'h10, 32'h1);
		wr(8'h20, 32'h3);
		for (int e = 0; e < 4; e++) begin
			wr(base, 32'(e));
			tcc_pins_i.pulse(k, 3, 5);
			rd(base + 8'h8, d);
			chk(d & 32'h7, lev[e]);
		end
		repeat (4) rd(base + 8'h4, d);
		rd(8'hf0, d);
		wr(8'hf4, 32'h1 << (10 + k));
		rd(8'hf4, d);
		chk(d, 32'h1 << (10 + k));
		wr(base, 32'h9 | (t << 2));
		repeat (5) tcc_pins_i.pulse(k, 3, 4);
		chk({31'h0, irq}, 32'h1);
		rd(base + 8'h8, d);
		chk(d & 32'h17, 32'h14);
		rd(base + 8'h4, prev);
		for (int i = 0; i < 3; i++) begin
			rd(base + 8'h4, d);
			chk(d - prev, t ? 32'h4 : 32'h8);
			prev = d;
		end
		wr(base + 8'h8, 32'h10);
		rd(base + 8'h8, d);
		chk(d & 32'h17, 32'h0);
		rd(8'hf0, d);
		wait_irq(1'b0);
		wrap_up();
	end
endmodule : tcc_top_tb

bind tcc_top tcc_top_chk tcc_top_chk_i (.clk(clk), .resetn(resetn),
	.bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
	.bus_rd(bus_rd), .bus_rdata(bus_rdata), .capture_pin(capture_pin),
	.compare_pin(compare_pin), .irq(irq));
